// ==== common/mprb_pkg.sv ====
// Package with timing, boot-code and carrier types for the power/reset sequencer
package mprb_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int unsigned CLK_HZ = 250000000;
	localparam int unsigned CARRIER_RAMP_MS = 100;
	localparam int unsigned CARRIER_RAMP_FLOOR_MS = 10;
	localparam int unsigned RESET_STRETCH_MS = 1;
	localparam int unsigned TIMER_W = 25;
	// Least times convert to whole cycles with no rounding up
	localparam int unsigned CARRIER_RAMP_CYC =
		(CARRIER_RAMP_MS * (CLK_HZ / 1000) + 0) ;
	localparam int unsigned CARRIER_RAMP_FLOOR_CYC =
		CARRIER_RAMP_FLOOR_MS * (CLK_HZ / 1000);
	localparam int unsigned RESET_STRETCH_CYC =
		RESET_STRETCH_MS * (CLK_HZ / 1000);

	// ************************************************************
	// Pin synchroniser depth and reset values
	// ************************************************************
	localparam int unsigned SYNC_STAGES = 3;
	localparam logic [2:0] STRAP_RESET = 3'h7;
	localparam logic [2:0] BOOT_CODE_RESET = 3'h6;

	// ************************************************************
	// Boot source codes, strap 2 is the most significant bit
	// ************************************************************
	typedef enum logic [2:0] {
		BOOT_HOST_SATA = 3'h0,
		BOOT_HOST_SD = 3'h1,
		BOOT_HOST_ESPI = 3'h2,
		BOOT_HOST_SPI = 3'h3,
		BOOT_MOD_USB = 3'h4,
		BOOT_NETWORK = 3'h5,
		BOOT_MOD_EMMC = 3'h6,
		BOOT_MOD_SPI = 3'h7
	} mprb_boot_src_t;

	// Decoded boot selection handed to the first-stage loader
	typedef struct packed {
		mprb_boot_src_t source;
		logic first_stage_sd;
		logic spi_requested;
		logic valid;
	} mprb_boot_info_t;

	// Power and reset outputs that face the carrier and the module
	typedef struct packed {
		logic power_management_chip_en;
		logic host_board_power_enable;
		logic reset_out_n;
		logic internal_reset;
	} mprb_power_ctl_t;

endpackage

// ==== rtl/mprb_sync.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree
module mprb_sync
#(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : bit_sync
			logic ff1;
			logic ff2;
			logic ff3;

			// The first stage feeds only the second stage
			always_ff @(posedge i_clk)
			begin
				if (i_srst)
				begin
					ff1 <= RESET_VAL[g];
					ff2 <= RESET_VAL[g];
					ff3 <= RESET_VAL[g];
				end
				else
				begin
					ff1 <= i_async[g];
					ff2 <= ff1;
					ff3 <= ff2;
				end
			end

			always_ff @(posedge i_clk)
			begin
				if (i_srst)
					o_sync[g] <= RESET_VAL[g];
				else if (ff2 == ff3)
					o_sync[g] <= ff3;
			end
		end
	endgenerate

endmodule

// ==== rtl/mprb_timer.sv ====
// Saturating interval counter on the free-running module clock
module mprb_timer
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_clear,
	input wire logic [mprb_pkg::TIMER_W-1:0] i_limit,
	output logic o_expired
);

	logic [mprb_pkg::TIMER_W-1:0] count;

	// Saturates at the limit so a long stay never wraps to a false short count
	always_ff @(posedge i_clk)
	begin
		if (i_srst || i_clear)
			count <= '0;
		else if (count < i_limit)
			count <= count + 1'b1;
	end

	// Expiry reads the count only; the clear depends on the next state,
	// which depends on expiry, so gating it here would close a comb loop
	assign o_expired = (count >= i_limit);

endmodule

// ==== rtl/mprb_seq.sv ====
// Power-up, reset-stretch and boot-strap sequencer of the computing module
//
// Operation
// - Power chip enabled only while supply good
// - Carrier power enable after module supplies up
// - Reset output held 100ms after carrier enable
// - Reset request holds both resets asserted
// - Resets stay 1ms after request released
// - Straps weakly pulled up, decoded in logic
// - Strap code maps to eight boot sources
// - SPI boot sources are decoded and flagged on o_spi_requested
// - Alternate strap open boots eMMC first
// - Alternate strap grounded boots SD first
module mprb_seq
#(
	parameter int unsigned CARRIER_RAMP_CYC = mprb_pkg::CARRIER_RAMP_CYC,
	parameter int unsigned RESET_STRETCH_CYC = mprb_pkg::RESET_STRETCH_CYC
)
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_input_supply_ok_n,
	input wire logic i_module_supplies_up,
	input wire logic i_reset_req_n,
	input wire logic [2:0] i_boot_strap_n,
	input wire logic i_alt_boot_n,
	output logic o_pin_pullup_en,
	output logic o_power_management_chip_en,
	output logic o_host_board_power_enable,
	output logic o_reset_out_n,
	output logic o_internal_reset,
	output logic [2:0] o_boot_code,
	output mprb_pkg::mprb_boot_src_t o_boot_source,
	output logic o_first_stage_sd,
	output logic o_spi_requested,
	output logic o_boot_valid
);

	// ************************************************************
	// State encoding
	// ************************************************************
	typedef enum logic [5:0] {
		ST_OFF = 6'h01,
		ST_CHIP_RAMP = 6'h02,
		ST_CARRIER_RAMP = 6'h04,
		ST_RUN = 6'h08,
		ST_RESET_HOLD = 6'h10,
		ST_RESET_STRETCH = 6'h20
	} mprb_state_t;

	// ************************************************************
	// Decoding helpers
	// ************************************************************
	function automatic mprb_pkg::mprb_boot_src_t decode_src(
		input logic [2:0] code
	);
		decode_src = mprb_pkg::mprb_boot_src_t'(code);
	endfunction

	function automatic logic is_spi(input mprb_pkg::mprb_boot_src_t src);
		is_spi = (src == mprb_pkg::BOOT_HOST_SPI) ||
			(src == mprb_pkg::BOOT_HOST_ESPI) ||
			(src == mprb_pkg::BOOT_MOD_SPI);
	endfunction

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic supply_ok_n_s;
	logic supplies_up_s;
	logic reset_req_n_s;
	logic [2:0] strap_n_s;
	logic alt_boot_n_s;

	// All carrier pins arrive asynchronously
	mprb_sync #(
		.WIDTH(7),
		.RESET_VAL(7'h7f)
	) u_pin_sync (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_async({i_input_supply_ok_n, i_reset_req_n, i_boot_strap_n,
			i_alt_boot_n, i_module_supplies_up}),
		.o_sync({supply_ok_n_s, reset_req_n_s, strap_n_s, alt_boot_n_s,
			supplies_up_s})
	);

	// Held up-pulled supply input reads as good; low means power bad
	logic supply_good;
	assign supply_good = supply_ok_n_s;

	// ************************************************************
	// Interval timer
	// ************************************************************
	mprb_state_t state;
	mprb_state_t next_state;
	logic timer_clear;
	logic timer_expired;
	logic [mprb_pkg::TIMER_W-1:0] timer_limit;

	// Timer restarts on every state change, so each wait is measured alone
	assign timer_clear = (next_state != state);
	assign timer_limit = (state == ST_RESET_STRETCH) ?
		mprb_pkg::TIMER_W'(RESET_STRETCH_CYC) :
		mprb_pkg::TIMER_W'(CARRIER_RAMP_CYC);

	mprb_timer u_timer (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_clear(timer_clear),
		.i_limit(timer_limit),
		.o_expired(timer_expired)
	);

	// ************************************************************
	// Sequencing
	// ************************************************************
	always_comb
	begin
		next_state = state;
		case (state)
			ST_OFF:
				if (supply_good)
					next_state = ST_CHIP_RAMP;
			ST_CHIP_RAMP:
				if (supplies_up_s)
					next_state = ST_CARRIER_RAMP;
			ST_CARRIER_RAMP:
				if (timer_expired)
					next_state = ST_RUN;
			ST_RUN:
				if (!reset_req_n_s)
					next_state = ST_RESET_HOLD;
			ST_RESET_HOLD:
				if (reset_req_n_s)
					next_state = ST_RESET_STRETCH;
			ST_RESET_STRETCH:
				if (!reset_req_n_s)
					next_state = ST_RESET_HOLD;
				else if (timer_expired)
					next_state = ST_RUN;
			default:
				next_state = ST_OFF;
		endcase
		// Power bad drops everything at once; a lost module rail falls back to ST_CHIP_RAMP
		if (!supply_good)
			next_state = ST_OFF;
		else if (!supplies_up_s && (state != ST_OFF) &&
			(state != ST_CHIP_RAMP))
			next_state = ST_CHIP_RAMP;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			state <= ST_OFF;
		else
			state <= next_state;
	end

	// ************************************************************
	// Power and reset outputs
	// ************************************************************
	mprb_pkg::mprb_power_ctl_t next_ctl;
	mprb_pkg::mprb_power_ctl_t ctl;

	always_comb
	begin
		next_ctl.power_management_chip_en = (next_state != ST_OFF);
		next_ctl.host_board_power_enable = (next_state == ST_CARRIER_RAMP) ||
			(next_state == ST_RUN) || (next_state == ST_RESET_HOLD) ||
			(next_state == ST_RESET_STRETCH);
		next_ctl.reset_out_n = (next_state == ST_RUN);
		next_ctl.internal_reset = (next_state != ST_RUN);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			ctl.power_management_chip_en <= 1'b0;
			ctl.host_board_power_enable <= 1'b0;
			ctl.reset_out_n <= 1'b0;
			ctl.internal_reset <= 1'b1;
		end
		else
			ctl <= next_ctl;
	end

	assign o_power_management_chip_en = ctl.power_management_chip_en;
	assign o_host_board_power_enable = ctl.host_board_power_enable;
	assign o_reset_out_n = ctl.reset_out_n;
	assign o_internal_reset = ctl.internal_reset;

	// Weak pull-ups on straps and reset request are always on
	assign o_pin_pullup_en = 1'b1;

	// ************************************************************
	// Boot strap capture
	// ************************************************************
	logic release_now;
	mprb_pkg::mprb_boot_info_t boot;
	logic [2:0] boot_code;

	// Latch only at the edge where the resets let go, so a strap moved
	// while running cannot change the boot source mid-boot
	assign release_now = (next_state == ST_RUN) && (state != ST_RUN);

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			boot_code <= mprb_pkg::BOOT_CODE_RESET;
			boot.source <= decode_src(mprb_pkg::BOOT_CODE_RESET);
			boot.first_stage_sd <= 1'b0;
			boot.spi_requested <= 1'b0;
			boot.valid <= 1'b0;
		end
		else if (release_now)
		begin
			// Grounded reads as 0, floating as 1
			boot_code <= strap_n_s;
			boot.source <= decode_src(strap_n_s);
			boot.first_stage_sd <= !alt_boot_n_s;
			boot.spi_requested <= is_spi(decode_src(strap_n_s));
			boot.valid <= 1'b1;
		end
		else if (next_state != ST_RUN)
			boot.valid <= 1'b0;
	end

	assign o_boot_code = boot_code;
	assign o_boot_source = boot.source;
	assign o_first_stage_sd = boot.first_stage_sd;
	assign o_spi_requested = boot.spi_requested;
	assign o_boot_valid = boot.valid;

endmodule

// ==== verification/mprb_carrier.sv ====
// Behavioural carrier board: supply flag, reset button and boot straps
module mprb_carrier
(
	input wire logic i_clk,
	input wire logic i_pullup_en,
	input wire logic i_main_good,
	input wire logic i_host_enable,
	input wire logic i_press_reset,
	input wire logic [2:0] i_strap_gnd,
	input wire logic i_alt_gnd,
	output logic o_supply_ok_n,
	output logic o_reset_req_n,
	output logic [2:0] o_boot_strap_n,
	output logic o_alt_boot_n,
	output logic [2:0] o_rails,
	output logic o_sd_slot_power_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rail_hi;
	logic rail_mid;
	logic rail_lo;
	// ********
	// Peripheral rails step up highest first and down lowest first
	// ********
	always_ff @(posedge i_clk)
	begin
		rail_hi <= i_host_enable || rail_mid;
		rail_mid <= rail_hi && (i_host_enable || rail_lo);
		rail_lo <= rail_mid && i_host_enable;
	end
	assign o_rails = {rail_hi, rail_mid, rail_lo};
	// Pulled up on the carrier so SD boot stays available
	assign o_sd_slot_power_enable = 1'b1;
	// ********
	// Open-drain lines: released means the pull-up level; the supply flag follows i_main_good directly
	// ********
	assign o_supply_ok_n = i_main_good;
	assign o_reset_req_n = i_pullup_en & !i_press_reset;
	assign o_boot_strap_n = ~i_strap_gnd & {3{i_pullup_en}};
	assign o_alt_boot_n = !i_alt_gnd & i_pullup_en;
endmodule

// ==== verification/mprb_seq_asserts.sv ====
// Concurrent checks on the sequencer ports
module mprb_seq_asserts
#(
	parameter int unsigned CARRIER_RAMP_CYC = 40,
	parameter int unsigned RESET_STRETCH_CYC = 10
)
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_input_supply_ok_n,
	input wire logic i_module_supplies_up,
	input wire logic i_reset_req_n,
	input wire logic o_pin_pullup_en,
	input wire logic o_power_management_chip_en,
	input wire logic o_host_board_power_enable,
	input wire logic o_reset_out_n,
	input wire logic o_internal_reset,
	input wire logic [2:0] o_boot_code,
	input wire mprb_pkg::mprb_boot_src_t o_boot_source,
	input wire logic o_spi_requested,
	input wire logic o_boot_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// Helper counters
	// ********
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	logic [31:0] en_cnt;
	logic [31:0] hi_cnt;
	always_ff @(posedge i_clk)
	begin
		en_cnt <= o_host_board_power_enable ? en_cnt + 32'h1 : 32'h0;
	end
	// Starts high so power-up is not taken for a short request
	always_ff @(posedge i_clk)
	begin
		if (i_srst || !i_reset_req_n)
			hi_cnt <= i_srst ? 32'h10000 : 32'h0;
		else
			hi_cnt <= hi_cnt + 32'h1;
	end
	// ********
	// Assertions
	// ********
	a_supply_bad_off: assert property (!i_input_supply_ok_n [*6] |->
		!o_power_management_chip_en && !o_host_board_power_enable)
		else $error("power on while supply bad");
	a_chip_on: assert property (i_input_supply_ok_n [*8] |->
		o_power_management_chip_en) else $error("power chip not enabled");
	a_carrier_order: assert property (o_host_board_power_enable |->
		o_power_management_chip_en) else $error("carrier before module");
	a_rails_down: assert property (!i_module_supplies_up [*6] |->
		!o_host_board_power_enable) else $error("carrier on, rails down");
	a_ramp_min: assert property (o_reset_out_n |->
		en_cnt > CARRIER_RAMP_CYC) else $error("reset released early");
	a_req_holds: assert property (!i_reset_req_n [*7] |->
		!o_reset_out_n && o_internal_reset) else $error("request ignored");
	a_stretch_min: assert property ($rose(o_reset_out_n) |->
		hi_cnt > RESET_STRETCH_CYC) else $error("stretch too short");
	a_stretch_ends: assert property (hi_cnt == RESET_STRETCH_CYC + 9 &&
		en_cnt > CARRIER_RAMP_CYC + 9 |-> o_reset_out_n)
		else $error("stretch too long");
	a_resets_pair: assert property (o_internal_reset == !o_reset_out_n)
		else $error("resets differ");
	a_code_held: assert property (o_boot_valid && $past(o_boot_valid) |->
		$stable(o_boot_code)) else $error("boot code moved");
	a_source_code: assert property (o_boot_source == o_boot_code)
		else $error("source differs from code");
	a_spi_flag: assert property (o_boot_valid |-> o_spi_requested ==
		(o_boot_code inside {3'h2, 3'h3, 3'h7})) else $error("spi flag");
	a_pullup_on: assert property (o_pin_pullup_en)
		else $error("pull-up off");
endmodule
bind mprb_seq mprb_seq_asserts #(.CARRIER_RAMP_CYC(CARRIER_RAMP_CYC),
	.RESET_STRETCH_CYC(RESET_STRETCH_CYC)) mprb_seq_asserts_i (.*);

// ==== verification/mprb_seq_tb.sv ====
// Self-checking bench for the power, reset and boot-strap sequencer
module mprb_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned RAMP = 40;
	localparam int unsigned STR = 10;
	typedef struct packed
	{
		logic [2:0] gnd;
		logic alt;
		logic spi;
	} mprb_row_t;
	logic i_clk, i_srst, i_module_supplies_up, good, press, alt, pu, pm, he;
	logic ok_n, req_n, alt_n, rst_n, irst, sd, spi, valid, sd_pe;
	logic [2:0] gnd, strap_n, code, rails;
	mprb_pkg::mprb_boot_src_t src;
	int num_errors, total_checks, n;
	int cycles = 0;
	mprb_row_t rows [8] = '{'{3'h7, 1'h0, 1'h0}, '{3'h6, 1'h1, 1'h0},
		'{3'h5, 1'h0, 1'h1}, '{3'h4, 1'h1, 1'h1}, '{3'h3, 1'h0, 1'h0},
		'{3'h2, 1'h1, 1'h0}, '{3'h1, 1'h0, 1'h0}, '{3'h0, 1'h1, 1'h1}};
	mprb_carrier mprb_carrier_i (.i_clk(i_clk), .i_pullup_en(pu),
		.i_main_good(good), .i_host_enable(he),
		.i_press_reset(press), .i_strap_gnd(gnd), .i_alt_gnd(alt),
		.o_supply_ok_n(ok_n), .o_reset_req_n(req_n),
		.o_boot_strap_n(strap_n), .o_alt_boot_n(alt_n), .o_rails(rails),
		.o_sd_slot_power_enable(sd_pe));
	mprb_seq #(.CARRIER_RAMP_CYC(RAMP), .RESET_STRETCH_CYC(STR)) mprb_seq_i (
		.i_clk(i_clk), .i_srst(i_srst), .i_input_supply_ok_n(ok_n),
		.i_module_supplies_up(i_module_supplies_up), .i_reset_req_n(req_n),
		.i_boot_strap_n(strap_n), .i_alt_boot_n(alt_n), .o_pin_pullup_en(pu),
		.o_power_management_chip_en(pm), .o_host_board_power_enable(he),
		.o_reset_out_n(rst_n), .o_internal_reset(irst), .o_boot_code(code),
		.o_boot_source(src), .o_first_stage_sd(sd), .o_spi_requested(spi),
		.o_boot_valid(valid));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		if (seen !== exp)
		begin
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
			num_errors++;
		end
		total_checks++;
	endtask
	task automatic wait_rel(output int c);
		c = 0;
		while (rst_n !== 1'b1 && c < 300)
		begin
			@(negedge i_clk);
			c++;
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	// Whole run is under 500 cycles; the ceiling leaves wide margin
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			end_sim();
		end
	end
	initial
	begin
		{i_srst, good, i_module_supplies_up, gnd} = 6'h39;
		{press, alt, num_errors, total_checks} = '0;
		// Synchronisers load their idle levels while reset is held
		repeat (3) @(negedge i_clk);
		check({pm, he, rst_n, irst, code, valid, pu}, 9'h039);
		i_srst = 1'b0;
		n = 0;
		while (he !== 1'b1 && n < 20)
		begin
			@(negedge i_clk);
			n++;
		end
		check(pm, 1'h1);
		wait_rel(n);
		check(n, RAMP + 1);
		check({irst, code, sd, valid}, 6'h19);
		check({rails, sd_pe}, 4'hf);
		foreach (rows[i])
		begin
			{gnd, alt} = {rows[i].gnd, rows[i].alt};
			press = 1'b1;
			repeat (8) @(negedge i_clk);
			check({rst_n, irst, valid}, 3'h2);
			press = i[0];
			repeat (3) @(negedge i_clk);
			press = 1'b0;
			wait_rel(n);
			check(n >= STR + 1 && n <= STR + 8, 1'h1);
			check({code, src}, {~rows[i].gnd, ~rows[i].gnd});
			check({sd, spi, valid}, {rows[i].alt, rows[i].spi, 1'h1});
		end
		// A request inside the stretch must restart it from its release
		press = 1'b1;
		repeat (8) @(negedge i_clk);
		press = 1'b0;
		repeat (6) @(negedge i_clk);
		press = 1'b1;
		repeat (3) @(negedge i_clk);
		press = 1'b0;
		wait_rel(n);
		check(n >= STR + 1 && n <= STR + 8, 1'h1);
		gnd = 3'h7;
		repeat (10) @(negedge i_clk);
		check(code, 3'h7);
		i_module_supplies_up = 1'b0;
		repeat (8) @(negedge i_clk);
		check({pm, he, rst_n}, 3'h4);
		check(rails, 3'h0);
		i_module_supplies_up = 1'b1;
		wait_rel(n);
		check(n >= RAMP + 1 && n <= RAMP + 12, 1'h1);
		good = 1'b0;
		repeat (8) @(negedge i_clk);
		check({pm, he, rst_n, valid}, 4'h0);
		good = 1'b1;
		wait_rel(n);
		check({rst_n, code, valid}, 5'h11);
		end_sim();
	end
endmodule
